// file: rtl/ccc_pkg.sv
// Shared constants and types of the coil chopper control block
package ccc_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CONF = 8'h00; // Chopper configuration
  localparam logic [7:0] ADDR_STAT = 8'h04; // Live chopper status
  localparam logic [31:0] CONF_RESET = 32'h0000_0000; // Coils free-wheel

  // Configuration field positions
  localparam int F_OFF_TIME_SETTING = 0; // off_time_setting, 4 bits
  localparam int F_HYSTERESIS_START_OFFSET = 4; // hysteresis_start_offset, 3 bits
  localparam int F_HYSTERESIS_END_VALUE = 7; // hysteresis_end_value, 4 bits
  localparam int F_FD3 = 11; // fast_decay_high_bit
  localparam int F_DISFDCC = 12; // Fast decay ends by time only
  localparam int F_TBL = 13; // blank_time_select, 2 bits
  localparam int F_CHM = 15; // Chopper mode select
  localparam logic [31:0] CONF_MASK = 32'h0000_FFFF; // Writable bits

  // Status field positions
  localparam int S_STATE0 = 0; // Coil A phase, 5 bits
  localparam int S_STATE1 = 8; // Coil B phase, 5 bits
  localparam int S_THR0 = 16; // Coil A threshold offset, 6 bits
  localparam int S_THR1 = 24; // Coil B threshold offset, 6 bits

  // Phase timing in system clocks
  localparam logic [9:0] SLOW_BASE = 10'h018; // Slow decay base, 24
  localparam logic [9:0] SLOW_STEP = 10'h020; // Per off-time step, 32
  localparam logic [9:0] FAST_STEP = 10'h020; // Per fast-decay step, 32
  localparam logic [5:0] BLANK_0 = 6'h10; // 16 clocks
  localparam logic [5:0] BLANK_1 = 6'h18; // 24 clocks
  localparam logic [5:0] BLANK_2 = 6'h24; // 36 clocks
  localparam logic [5:0] BLANK_3 = 6'h36; // 54 clocks
  localparam logic [3:0] HYSTERESIS_DECREMENTER_LAST = 4'hF; // Step every 16 clocks
  localparam logic [5:0] HYSTERESIS_END_VALUE_BIAS = 6'h03; // End field minus three
  localparam logic [5:0] HYSTERESIS_START_OFFSET_BIAS = 6'h01; // Start field plus one

  // Drive codes toward the bridge
  localparam logic [1:0] DRV_FREE = 2'h0; // All transistors off
  localparam logic [1:0] DRV_ON = 2'h1; // Current rising
  localparam logic [1:0] DRV_FAST = 2'h2; // Fast decay
  localparam logic [1:0] DRV_SLOW = 2'h3; // Slow decay

  // Chopper phases, one-hot
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_ON = 5'h02,
    ST_SLOW1 = 5'h04,
    ST_FAST = 5'h08,
    ST_SLOW2 = 5'h10
  } ccc_state_t;

endpackage

// file: rtl/ccc_timer.sv
// Down counter used for phase durations and comparator blanking
`timescale 1ns/1ps
module ccc_timer #(
  parameter int W = 10 // Counter width
) (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic load, // Restart with load_val
  input wire logic [W-1:0] load_val, // Cycles minus one
  output logic done // Count has reached zero
);

  logic [W-1:0] cnt_q; // Remaining cycles
  logic [W-1:0] cnt_d; // Next remaining cycles

  // Reload or count down, stop at zero
  always_comb begin
    if (load) begin
      cnt_d = load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end else begin
      cnt_d = cnt_q;
    end
  end

  // Count register
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == '0);

endmodule

// file: rtl/ccc_hyst.sv
// Hysteresis decrementer for one coil
`timescale 1ns/1ps
module ccc_hyst (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic load, // New chopper cycle begins
  input wire logic [2:0] hysteresis_start_offset, // hysteresis_start_offset
  input wire logic [3:0] hysteresis_end_value, // hysteresis_end_value
  output logic signed [5:0] hyst // Active hysteresis
);

  logic signed [5:0] end_val; // Effective end value
  logic signed [5:0] start_val; // Effective start value
  logic signed [5:0] hyst_q; // Active hysteresis
  logic signed [5:0] hyst_d; // Next hysteresis
  logic [3:0] pre_q; // Clock prescaler
  logic [3:0] pre_d; // Next prescaler

  // Decode fields into signed end and start values
  always_comb begin
    end_val = $signed({2'b00, hysteresis_end_value} - ccc_pkg::HYSTERESIS_END_VALUE_BIAS);
    start_val = end_val + $signed({3'b000, hysteresis_start_offset}) +
      $signed(ccc_pkg::HYSTERESIS_START_OFFSET_BIAS);
  end

  // Reload at cycle start, step down every sixteen clocks
  always_comb begin
    pre_d = pre_q + 4'h1;
    hyst_d = hyst_q;
    if (load) begin
      pre_d = 4'h0;
      hyst_d = start_val;
    end else if (pre_q == ccc_pkg::HYSTERESIS_DECREMENTER_LAST) begin
      if (hyst_q > end_val) begin
        hyst_d = hyst_q - 6'sd1;
      end else begin
        hyst_d = end_val;
      end
    end
  end

  // Hysteresis and prescaler registers
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_q <= 4'h0;
      hyst_q <= 6'sh00;
    end else begin
      pre_q <= pre_d;
      hyst_q <= hyst_d;
    end
  end

  assign hyst = hyst_q;

endmodule

// file: rtl/ccc_top.sv
// Two-coil cycle-by-cycle current chopper with AHB-Lite registers
//
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module ccc_top (
  input wire logic SYS_CLK, // System clock, 125 MHz
  input wire logic RST, // Synchronous reset, active high
  input wire logic HSEL, // AHB slave select
  input wire logic [31:0] HADDR, // AHB address
  input wire logic [1:0] HTRANS, // AHB transfer type
  input wire logic HWRITE, // AHB write strobe
  input wire logic [2:0] HSIZE, // AHB transfer size
  input wire logic [31:0] HWDATA, // AHB write data
  input wire logic HREADY, // AHB bus ready
  output logic HREADYOUT, // AHB slave ready
  output logic [31:0] HRDATA, // AHB read data
  output logic HRESP, // AHB response, always OKAY
  input wire logic [1:0] COIL_CMP, // Comparator per coil
  input wire logic FULLSTEP_DC_ACTIVE, // Full-step speed control
  output logic [3:0] COIL_DRIVE, // Bridge drive code per coil
  output logic [11:0] COIL_THRESH // Threshold offset per coil
);

  // ------------------------------------------------------------
  // Bus slave state
  // ------------------------------------------------------------
  logic wr_pend_q; // Write data phase in progress
  logic wr_pend_d; // Next write pending
  logic [7:0] wr_addr_q; // Latched write offset
  logic [7:0] wr_addr_d; // Next write offset
  logic [31:0] rdata_q; // Read data register
  logic [31:0] rdata_d; // Next read data
  logic ready_q; // Ready output register
  logic resp_q; // Response output register
  logic [31:0] conf_q; // Configuration register
  logic [31:0] conf_d; // Next configuration
  logic addr_take; // Valid address phase this cycle
  logic [7:0] addr_off; // Word-aligned offset of this phase
  logic [31:0] conf_view; // Configuration with pending write

  // Live status from both coils
  logic [9:0] state_all; // Coil phase codes
  logic [11:0] thr_all; // Coil threshold offsets

  // Decoded configuration fields
  logic [3:0] off_time_setting; // off_time_setting
  logic [2:0] hysteresis_start_offset; // hysteresis_start_offset
  logic [3:0] hysteresis_end_value; // hysteresis_end_value
  logic fd3; // fast_decay_high_bit
  logic disfdcc; // Fast decay ends by time only
  logic [1:0] blank_time_select; // blank_time_select
  logic chm; // Chopper mode select bit
  logic classic; // Classic chopper in effect
  logic [3:0] fast_decay_time; // fast_decay_time
  logic [5:0] blank_m1; // Blank length minus one
  logic [9:0] slow_m1; // Slow decay length minus one
  logic [9:0] fast_m1; // Fast decay length minus one
  logic signed [5:0] offset; // Classic sine offset

  // Address phase qualifies only when selected and the bus is ready
  always_comb begin
    addr_take = HSEL & HREADY & HTRANS[1];
    addr_off = {HADDR[7:2], 2'b00};
  end

  // Configuration as seen by a read that follows a write directly
  always_comb begin
    conf_view = conf_q;
    if (wr_pend_q && wr_addr_q == ccc_pkg::ADDR_CONF) begin
      conf_view = HWDATA & ccc_pkg::CONF_MASK;
    end
  end

  // Next bus state: latch writes, prepare read data
  always_comb begin
    wr_pend_d = addr_take & HWRITE;
    wr_addr_d = wr_addr_q;
    rdata_d = rdata_q;
    conf_d = conf_q;
    if (addr_take) begin
      wr_addr_d = addr_off;
    end
    // Write data phase stores into the configuration register; other offsets ignore writes
    if (wr_pend_q && wr_addr_q == ccc_pkg::ADDR_CONF) begin
      conf_d = HWDATA & ccc_pkg::CONF_MASK;
    end
    // Read data is captured at the address phase edge
    if (addr_take && !HWRITE) begin
      case (addr_off)
        ccc_pkg::ADDR_CONF: begin
          rdata_d = conf_view;
        end
        ccc_pkg::ADDR_STAT: begin
          rdata_d = 32'h0000_0000;
          rdata_d[ccc_pkg::S_STATE0 +: 5] = state_all[4:0];
          rdata_d[ccc_pkg::S_STATE1 +: 5] = state_all[9:5];
          rdata_d[ccc_pkg::S_THR0 +: 6] = thr_all[5:0];
          rdata_d[ccc_pkg::S_THR1 +: 6] = thr_all[11:6];
        end
        default: begin
          rdata_d = 32'h0000_0000; // Unmapped reads as zero
        end
      endcase
    end
  end

  // Bus registers; zero wait states, always OKAY
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      conf_q <= ccc_pkg::CONF_RESET;
      ready_q <= 1'b0;
      resp_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
      conf_q <= conf_d;
      ready_q <= 1'b1;
      resp_q <= 1'b0;
    end
  end

  assign HREADYOUT = ready_q;
  assign HRDATA = rdata_q;
  assign HRESP = resp_q;

  // ------------------------------------------------------------
  // Field decode shared by both coils
  // ------------------------------------------------------------
  always_comb begin
    off_time_setting = conf_q[ccc_pkg::F_OFF_TIME_SETTING +: 4];
    hysteresis_start_offset = conf_q[ccc_pkg::F_HYSTERESIS_START_OFFSET +: 3];
    hysteresis_end_value = conf_q[ccc_pkg::F_HYSTERESIS_END_VALUE +: 4];
    fd3 = conf_q[ccc_pkg::F_FD3];
    disfdcc = conf_q[ccc_pkg::F_DISFDCC];
    blank_time_select = conf_q[ccc_pkg::F_TBL +: 2];
    chm = conf_q[ccc_pkg::F_CHM];
    classic = chm | FULLSTEP_DC_ACTIVE;
    fast_decay_time = {fd3, hysteresis_start_offset};
    slow_m1 = ccc_pkg::SLOW_BASE + ccc_pkg::SLOW_STEP * {6'h00, off_time_setting}
      - 10'h001;
    fast_m1 = ccc_pkg::FAST_STEP * {6'h00, fast_decay_time} - 10'h001;
    offset = $signed({2'b00, hysteresis_end_value} - ccc_pkg::HYSTERESIS_END_VALUE_BIAS);
    case (blank_time_select)
      2'h0: blank_m1 = ccc_pkg::BLANK_0 - 6'h01;
      2'h1: blank_m1 = ccc_pkg::BLANK_1 - 6'h01;
      2'h2: blank_m1 = ccc_pkg::BLANK_2 - 6'h01;
      default: blank_m1 = ccc_pkg::BLANK_3 - 6'h01;
    endcase
  end

  // ------------------------------------------------------------
  // One independent chopper per coil
  // ------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_coil
    ccc_pkg::ccc_state_t state_q; // Current chopper phase
    ccc_pkg::ccc_state_t state_d; // Next chopper phase
    logic ph_load; // Restart phase timer
    logic [9:0] ph_val; // Phase length minus one
    logic ph_done; // Phase time expired
    logic bl_load; // Restart blanking
    logic bl_done; // Blanking over
    logic cmp_ok; // Comparator result is trusted
    logic cyc_start; // New chopper cycle
    logic signed [5:0] hyst; // Active hysteresis
    logic [1:0] drv_q; // Drive code register
    logic [1:0] drv_d; // Next drive code
    logic [5:0] thr_q; // Threshold offset register
    logic [5:0] thr_d; // Next threshold offset

    // Phase duration timer
    ccc_timer #(
      .W(10)
    ) u_phase (
      .clk(SYS_CLK),
      .rst(RST),
      .load(ph_load),
      .load_val(ph_val),
      .done(ph_done)
    );

    // Comparator blanking timer
    ccc_timer #(
      .W(6)
    ) u_blank (
      .clk(SYS_CLK),
      .rst(RST),
      .load(bl_load),
      .load_val(blank_m1),
      .done(bl_done)
    );

    // Hysteresis decrementer
    ccc_hyst u_hyst (
      .clk(SYS_CLK),
      .rst(RST),
      .load(cyc_start),
      .hysteresis_start_offset(hysteresis_start_offset),
      .hysteresis_end_value(hysteresis_end_value),
      .hyst(hyst)
    );

    // Phase sequencer
    always_comb begin
      state_d = state_q;
      ph_load = 1'b0;
      ph_val = slow_m1;
      bl_load = 1'b0;
      cyc_start = 1'b0;
      cmp_ok = bl_done & COIL_CMP[i];
      if (off_time_setting == 4'h0) begin
        state_d = ccc_pkg::ST_OFF;
      end else begin
        case (state_q)
          ccc_pkg::ST_OFF: begin
            state_d = ccc_pkg::ST_ON;
            bl_load = 1'b1;
            cyc_start = 1'b1;
          end
          ccc_pkg::ST_ON: begin
            // On ends only when the target current is reached
            if (cmp_ok) begin
              ph_load = 1'b1;
              if (classic && fast_decay_time != 4'h0) begin
                state_d = ccc_pkg::ST_FAST;
                ph_val = fast_m1;
                bl_load = 1'b1;
              end else begin
                state_d = ccc_pkg::ST_SLOW1;
              end
            end
          end
          ccc_pkg::ST_SLOW1: begin
            if (ph_done) begin
              bl_load = 1'b1;
              if (classic) begin
                state_d = ccc_pkg::ST_ON;
                cyc_start = 1'b1;
              end else begin
                state_d = ccc_pkg::ST_FAST;
              end
            end
          end
          ccc_pkg::ST_FAST: begin
            if (classic) begin
              // Timed end, or early end on comparator if enabled
              if (ph_done || (!disfdcc && cmp_ok)) begin
                state_d = ccc_pkg::ST_SLOW1;
                ph_load = 1'b1;
              end
            end else if (cmp_ok) begin
              state_d = ccc_pkg::ST_SLOW2;
              ph_load = 1'b1;
            end
          end
          ccc_pkg::ST_SLOW2: begin
            if (ph_done) begin
              state_d = ccc_pkg::ST_ON;
              bl_load = 1'b1;
              cyc_start = 1'b1;
            end
          end
          default: begin
            state_d = ccc_pkg::ST_OFF;
          end
        endcase
      end
    end

    // Drive code and threshold offset toward the bridge
    always_comb begin
      case (state_d)
        ccc_pkg::ST_ON: drv_d = ccc_pkg::DRV_ON;
        ccc_pkg::ST_FAST: drv_d = ccc_pkg::DRV_FAST;
        ccc_pkg::ST_SLOW1: drv_d = ccc_pkg::DRV_SLOW;
        ccc_pkg::ST_SLOW2: drv_d = ccc_pkg::DRV_SLOW;
        default: drv_d = ccc_pkg::DRV_FREE;
      endcase
      thr_d = classic ? offset : hyst;
    end

    // Sequencer and output registers
    always_ff @(posedge SYS_CLK) begin
      if (RST) begin
        state_q <= ccc_pkg::ST_OFF;
        drv_q <= ccc_pkg::DRV_FREE;
        thr_q <= 6'h00;
      end else begin
        state_q <= state_d;
        drv_q <= drv_d;
        thr_q <= thr_d;
      end
    end

    assign COIL_DRIVE[i*2 +: 2] = drv_q;
    assign COIL_THRESH[i*6 +: 6] = thr_q;
    assign state_all[i*5 +: 5] = state_q;
    assign thr_all[i*6 +: 6] = thr_q;
  end

endmodule

// file: tb/ccc_top_asserts.sv
// Checker for the coil drive sequence and the bus answer
`timescale 1ns/1ps
module ccc_top_asserts (
  input wire logic SYS_CLK, // System clock
  input wire logic RST, // Synchronous reset
  input wire logic HREADYOUT, // Slave ready
  input wire logic [3:0] COIL_DRIVE, // Drive codes
  input wire logic [11:0] COIL_THRESH // Threshold offsets
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic [1:0] da, db, da_q, db_q; // Drive codes now and one cycle ago
  logic [8:0] ca_q, cb_q, ca_d, cb_d; // Cycles spent in present code
  logic [5:0] ta; // Coil A threshold
  assign da = COIL_DRIVE[1:0];
  assign db = COIL_DRIVE[3:2];
  assign ta = COIL_THRESH[5:0];
  // Restart the count on a code change, saturate at the top
  always_comb begin
    ca_d = (da != da_q) ? 9'h000 : ca_q + {8'h00, ca_q != 9'h1FF};
    cb_d = (db != db_q) ? 9'h000 : cb_q + {8'h00, cb_q != 9'h1FF};
  end
  // Register the helper state
  always_ff @(posedge SYS_CLK) begin
    {da_q, db_q, ca_q, cb_q} <= RST ? 22'h0 : {da, db, ca_d, cb_d};
  end
  a_ready_high: assert property (!$past(RST) |-> HREADYOUT)
    else $error("ready low outside reset");
  a_blank_on_a: assert property (
    $past(da) == ccc_pkg::DRV_ON && da != ccc_pkg::DRV_ON &&
    da != ccc_pkg::DRV_FREE |-> ca_q >= 9'h00F)
    else $error("coil A on phase shorter than blanking");
  a_blank_fast_a: assert property (
    $past(da) == ccc_pkg::DRV_FAST && da != ccc_pkg::DRV_FAST &&
    da != ccc_pkg::DRV_FREE |-> ca_q >= 9'h00F)
    else $error("coil A fast decay shorter than blanking");
  a_slow_min_a: assert property (
    $past(da) == ccc_pkg::DRV_SLOW && da != ccc_pkg::DRV_SLOW &&
    da != ccc_pkg::DRV_FREE |-> ca_q >= 9'h037)
    else $error("coil A slow decay too short");
  a_free_to_on: assert property (
    $past(da) == ccc_pkg::DRV_FREE && da != ccc_pkg::DRV_FREE
    |-> da == ccc_pkg::DRV_ON)
    else $error("coil A left free-wheel other than to on");
  a_fast_then_slow: assert property (
    $past(da) == ccc_pkg::DRV_FAST && da != ccc_pkg::DRV_FAST &&
    da != ccc_pkg::DRV_FREE |-> da == ccc_pkg::DRV_SLOW)
    else $error("coil A fast decay not followed by slow decay");
  a_hyst_step_a: assert property (
    $changed(ta) && da != ccc_pkg::DRV_FREE && ca_q >= 9'h002
    ##1 da != ccc_pkg::DRV_FREE |-> $past(ta) == $past(ta, 2) - 6'h01)
    else $error("coil A threshold moved other than one step down");
  a_blank_on_b: assert property (
    $past(db) == ccc_pkg::DRV_ON && db != ccc_pkg::DRV_ON &&
    db != ccc_pkg::DRV_FREE |-> cb_q >= 9'h00F)
    else $error("coil B on phase shorter than blanking");
  c_on_slow: cover property ($past(da) == ccc_pkg::DRV_ON &&
    da == ccc_pkg::DRV_SLOW);
  c_on_fast: cover property ($past(da) == ccc_pkg::DRV_ON &&
    da == ccc_pkg::DRV_FAST);
  c_fast_slow: cover property ($past(da) == ccc_pkg::DRV_FAST &&
    da == ccc_pkg::DRV_SLOW);
endmodule

// file: tb/ccc_coil_model.sv
// Behavioural bridge and current comparator for both coils
`timescale 1ns/1ps
module ccc_coil_model (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [3:0] drive, // Drive codes per coil
  input wire logic [15:0] on_dly, // Cycles to target current, per coil
  input wire logic [7:0] fast_dly, // Cycles to negative limit
  output logic [1:0] cmp // Comparator per coil
);
  logic [1:0] last_q [2]; // Previous drive code
  logic [8:0] cnt_q [2]; // Cycles in present code
  // Current reaches its limit a set time into on and fast decay
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst || drive[2*i +: 2] != last_q[i]) begin
        cnt_q[i] <= 9'h000;
      end else if (cnt_q[i] != 9'h1FF) begin
        cnt_q[i] <= cnt_q[i] + 9'h001;
      end
      last_q[i] <= drive[2*i +: 2];
      cmp[i] <= !rst && ((drive[2*i +: 2] == ccc_pkg::DRV_ON &&
        cnt_q[i] >= {1'b0, on_dly[8*i +: 8]}) ||
        (drive[2*i +: 2] == ccc_pkg::DRV_FAST && cnt_q[i] >= {1'b0, fast_dly}));
    end
  end
endmodule

// file: tb/coil_chopper_control_tb_top.sv
// Self-checking bench for the coil chopper control block
`timescale 1ns/1ps
module coil_chopper_control_tb_top;
  logic SYS_CLK, RST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP; // Bus
  logic FULLSTEP_DC_ACTIVE; // Forces classic mode
  logic [31:0] HADDR, HWDATA, HRDATA; // Bus address and data
  logic [1:0] HTRANS, COIL_CMP; // Transfer type, comparators
  logic [2:0] HSIZE; // Transfer size
  logic [3:0] COIL_DRIVE; // Drive codes
  logic [11:0] COIL_THRESH; // Threshold offsets
  logic [15:0] on_dly; // Comparator delay in on phase
  logic [7:0] fast_dly; // Comparator delay in fast decay
  logic [31:0] rd; // Last read data
  logic [1:0] code; // Code after a phase change
  int failures, total_checks, cycles, len, len0; // Bookkeeping
  assign HREADY = HREADYOUT; // One slave drives bus ready
  always #4 SYS_CLK = ~SYS_CLK; // 125 MHz
  ccc_top ccc_top_i (.SYS_CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE, .HWDATA, .HREADY, .HREADYOUT, .HRDATA, .HRESP, .COIL_CMP,
    .FULLSTEP_DC_ACTIVE, .COIL_DRIVE, .COIL_THRESH);
  ccc_coil_model ccc_coil_model_i (.clk(SYS_CLK), .rst(RST),
    .drive(COIL_DRIVE), .on_dly(on_dly), .fast_dly(fast_dly), .cmp(COIL_CMP));
  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task close_out();
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One single word transfer; read data lands in rd
  // Waits as long as the slave stretches; only the bench timeout ends a hang
  task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= wr;
    do begin
      @(posedge SYS_CLK);
    end while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do begin
      @(posedge SYS_CLK);
    end while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask
  // Free-wheel both coils, then load a new setting
  task cfg(input logic [31:0] v);
    xfer(1'b1, 32'h0, 32'h0);
    xfer(1'b1, 32'h0, v);
  endtask
  // Wait for coil c to change code; len is the old phase length
  // A phase that never ends is caught by the bench timeout
  task phase(input int c);
    logic [1:0] old;
    #1;
    old = COIL_DRIVE[2*c +: 2];
    len = 0;
    do begin
      @(posedge SYS_CLK);
      #1;
      len++;
    end while (COIL_DRIVE[2*c +: 2] === old);
    code = COIL_DRIVE[2*c +: 2];
  endtask
  // Register access, masking and unmapped space
  task t_regs();
    xfer(1'b0, 32'h0, 32'h0);
    check(rd, ccc_pkg::CONF_RESET);
    xfer(1'b0, 32'h4, 32'h0);
    check(rd & 32'h0000_1F1F, 32'h0000_0101);
    xfer(1'b1, 32'h0, 32'hFFFF_5A50);
    xfer(1'b0, 32'h0, 32'h0);
    check(rd, 32'h0000_5A50);
    check(COIL_DRIVE, 4'h0);
    xfer(1'b1, 32'h8, 32'hFFFF_FFFF);
    xfer(1'b0, 32'h8, 32'h0);
    check(rd, 32'h0);
    xfer(1'b0, 32'h0, 32'h0);
    check(rd, 32'h0000_5A50);
    check(HRESP, 1'b0);
  endtask
  // Adaptive cycle order, slow time and hysteresis span
  task t_adaptive();
    on_dly <= 16'h1E00;
    cfg(32'h0000_0062);
    phase(0);
    check(code, ccc_pkg::DRV_ON);
    @(posedge SYS_CLK);
    #1;
    check(COIL_THRESH[5:0], 6'h04);
    phase(0);
    check(code, ccc_pkg::DRV_SLOW);
    check(COIL_DRIVE[3:2], ccc_pkg::DRV_ON);
    phase(0);
    check(len, 32'd88);
    check(code, ccc_pkg::DRV_FAST);
    phase(0);
    check(code, ccc_pkg::DRV_SLOW);
    phase(0);
    check(len, 32'd88);
    check(code, ccc_pkg::DRV_ON);
    check(COIL_THRESH[5:0], 6'h3D);
  endtask
  // Each blank setting lengthens the on phase by its own step
  task t_blank();
    logic [31:0] blank [4];
    blank = '{32'd16, 32'd24, 32'd36, 32'd54};
    on_dly <= 16'h0000;
    for (int k = 0; k < 4; k++) begin
      cfg(32'h1 | (32'(k) << 13));
      phase(0);
      phase(0);
      if (k == 0) len0 = len;
      check(len - len0, blank[k] - 32'd16);
    end
  endtask
  // Classic mode timed and comparator-ended fast decay, offset
  task t_classic();
    cfg(32'h0000_9F91);
    phase(0);
    @(posedge SYS_CLK);
    #1;
    check(COIL_THRESH[5:0], 6'h0C);
    check(COIL_THRESH[11:6], 6'h0C);
    phase(0);
    check(code, ccc_pkg::DRV_FAST);
    phase(0);
    check(len, 32'd288);
    check(code, ccc_pkg::DRV_SLOW);
    phase(0);
    check(len, 32'd56);
    fast_dly <= 8'd40;
    cfg(32'h0000_8F91);
    phase(0);
    phase(0);
    phase(0);
    check(len > 40 && len < 100, 1'b1);
    fast_dly <= 8'd0;
    cfg(32'h0000_8001);
    phase(0);
    @(posedge SYS_CLK);
    #1;
    check(COIL_THRESH[5:0], 6'h3D);
    phase(0);
    check(code, ccc_pkg::DRV_SLOW);
  endtask
  // Full-step speed control overrides the mode bit
  task t_fullstep();
    FULLSTEP_DC_ACTIVE <= 1'b1;
    cfg(32'h0000_01A1);
    phase(0);
    phase(0);
    check(code, ccc_pkg::DRV_FAST);
    xfer(1'b1, 32'h0, 32'h0);
    FULLSTEP_DC_ACTIVE <= 1'b0;
  endtask
  // Cut a hang short
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    SYS_CLK = 1'b0;
    RST = 1'b1;
    HSEL = 1'b1;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    FULLSTEP_DC_ACTIVE = 1'b0;
    on_dly = 16'h0000;
    fast_dly = 8'h00;
    repeat (8) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    t_regs();
    t_adaptive();
    t_blank();
    t_classic();
    t_fullstep();
    close_out();
  end
endmodule
bind ccc_top ccc_top_asserts ccc_top_asserts_i (.SYS_CLK(SYS_CLK), .RST(RST),
  .HREADYOUT(HREADYOUT), .COIL_DRIVE(COIL_DRIVE), .COIL_THRESH(COIL_THRESH));
